// File: hdl/ascfg_pkg.sv
// Constants and types shared by the scan and sequence configuration block.
package ascfg_pkg;

    localparam int WORD_W = 16;
    localparam int NIB_W = 4;
    localparam int SEQ_W = 8;
    localparam int IDX_W = 9;
    localparam int SEQ_DEPTH = 256;
    localparam int CHAN_N = 16;

    localparam int KIND_BIT = 15;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 11;
    localparam int FIELD_HI = 10;
    localparam int FIELD_LO = 3;
    localparam int MODE_PD_BIT = 3;

    localparam logic [4:0] SEL_UPPER_SCAN = 5'h14;
    localparam logic [4:0] SEL_LOWER_SCAN = 5'h15;
    localparam logic [4:0] SEL_SEQUENCE = 5'h16;

    localparam logic [3:0] LAST_WORD_BIT = 4'hF;
    localparam logic [1:0] LAST_NIB_BIT = 2'h3;
    localparam logic [NIB_W-1:0] INPUT_ZERO = 4'h0;
    localparam logic [2:0] SYNC_RST = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_WORD    = 3'b010,
        ST_PATTERN = 3'b100
    } ascfg_state_t;

    typedef struct packed {
        logic                                 cs_prev;
        logic                                 sclk_prev;
        ascfg_state_t                         state;
        logic [WORD_W-1:0]                    shift;
        logic [3:0]                           bitcnt;
        logic                                 pat_armed;
        logic                                 pat_pending;
        logic [IDX_W-1:0]                     nib_idx;
        logic [IDX_W-1:0]                     rcvd;
        logic [SEQ_DEPTH-1:0][NIB_W-1:0]      mem;
        logic [CHAN_N-1:0]                    scan_en;
        logic [SEQ_W-1:0]                     seq_count;
        logic [SEQ_W-1:0]                     act_len;
        logic [IDX_W-1:0]                     act_rcvd;
        logic                                 mode_pending;
        logic [WORD_W-1:0]                    mode_word;
        logic                                 running;
        logic [SEQ_W-1:0]                     seq_idx;
        logic [NIB_W-1:0]                     conv_chan;
        logic                                 conv_start;
        logic                                 data_valid;
        logic                                 pd_req;
        logic                                 power_down;
    } ascfg_regs_t;

endpackage

// File: hdl/ascfg_sync.sv
// Two-flop synchroniser for the serial port pins.
`timescale 1ns/1ps
module ascfg_sync #(
    parameter int         WIDTH = 3,
    parameter logic [2:0] RST_VAL = 3'h0
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_q   <= RST_VAL[WIDTH-1:0];
            sync_out <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// File: hdl/ascfg_top.sv
// Serial configuration decoder: scan enables, channel sequence and mode-word timing.
`timescale 1ns/1ps
module ascfg_top (
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    input  wire logic                               cs_n,
    input  wire logic                               sclk,
    input  wire logic                               din,
    output logic      [ascfg_pkg::CHAN_N-1:0]       scan_enable,
    output logic      [ascfg_pkg::SEQ_W-1:0]        sequence_count,
    output logic      [ascfg_pkg::NIB_W-1:0]        conv_channel,
    output logic                                    conv_start,
    output logic                                    seq_running,
    output logic                                    data_valid,
    output logic                                    power_down
);
    import ascfg_pkg::*;

    ascfg_regs_t r_q;
    ascfg_regs_t r_d;
    logic [2:0]  pins_s;
    logic        cs_s;
    logic        sclk_s;
    logic        din_s;

    ascfg_sync #(
        .WIDTH   (3),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({din, sclk, cs_n}),
        .sync_out (pins_s)
    );

    assign cs_s   = pins_s[0];
    assign sclk_s = pins_s[1];
    assign din_s  = pins_s[2];

    function automatic logic [4:0] sel_code(input logic [WORD_W-1:0] w);
        sel_code = w[SEL_HI:SEL_LO];
    endfunction

    function automatic logic [SEQ_W-1:0] field(input logic [WORD_W-1:0] w);
        field = w[FIELD_HI:FIELD_LO];
    endfunction

    // An index lies inside the programmed sequence when it does not exceed the count.
    function automatic logic in_len(input logic [IDX_W-1:0] idx, input logic [SEQ_W-1:0] cnt);
        in_len = (idx <= {1'b0, cnt});
    endfunction

    always_comb
    begin
        logic              cs_fall;
        logic              cs_rise;
        logic              sclk_rise;
        logic [WORD_W-1:0] w;
        logic [NIB_W-1:0]  nib;
        logic [IDX_W-1:0]  cidx;

        r_d       = r_q;
        cs_fall   = r_q.cs_prev & ~cs_s;
        cs_rise   = ~r_q.cs_prev & cs_s;
        sclk_rise = ~r_q.sclk_prev & sclk_s;
        w         = {r_q.shift[WORD_W-2:0], din_s};
        nib       = {r_q.shift[NIB_W-2:0], din_s};
        cidx      = '0;

        r_d.cs_prev    = cs_s;
        r_d.sclk_prev  = sclk_s;
        r_d.conv_start = 1'b0;

        if (cs_fall)
        begin
            if (r_q.pat_pending)
            begin
                // The stored pattern goes live only here, never mid-frame.
                r_d.act_len     = r_q.seq_count;
                r_d.act_rcvd    = r_q.rcvd;
                r_d.pat_pending = 1'b0;
            end
            if (r_q.mode_pending)
            begin
                // A queued mode word takes over at this edge.
                r_d.mode_pending = 1'b0;
                r_d.running      = 1'b1;
                r_d.seq_idx      = '0;
                r_d.data_valid   = 1'b1;
                r_d.power_down   = 1'b0;
                r_d.pd_req       = r_q.mode_word[MODE_PD_BIT];
            end
            if (r_d.running)
            begin
                cidx = {1'b0, r_d.seq_idx};
                // Entries never delivered read as input zero.
                r_d.conv_chan  = (cidx < r_d.act_rcvd) ? r_q.mem[r_d.seq_idx] : INPUT_ZERO;
                r_d.conv_start = 1'b1;
                if (r_d.seq_idx == r_d.act_len)
                begin
                    // Last entry: sequence length is the count plus one.
                    r_d.running    = 1'b0;
                    r_d.power_down = r_d.pd_req;
                end
                else
                begin
                    r_d.seq_idx = r_d.seq_idx + 1'b1;
                end
            end
            r_d.bitcnt = '0;
            r_d.shift  = '0;
            if (r_q.pat_armed)
            begin
                r_d.state     = ST_PATTERN;
                r_d.pat_armed = 1'b0;
                r_d.nib_idx   = '0;
                r_d.rcvd      = '0;
            end
            else
            begin
                r_d.state = ST_WORD;
            end
        end
        else if (cs_rise)
        begin
            if (r_q.state == ST_PATTERN)
            begin
                // A nibble cut short by chip select is stored as input zero.
                if ((r_q.bitcnt[1:0] != 2'h0) && in_len(r_q.nib_idx, r_q.seq_count))
                begin
                    r_d.mem[r_q.nib_idx[SEQ_W-1:0]] = INPUT_ZERO;
                    r_d.rcvd                         = r_q.nib_idx + 1'b1;
                end
                r_d.pat_pending = 1'b1;
            end
            r_d.state = ST_IDLE;
        end
        else if (sclk_rise && !cs_s)
        begin
            case (r_q.state)
                ST_WORD:
                begin
                    r_d.shift  = w;
                    r_d.bitcnt = r_q.bitcnt + 1'b1;
                    if (r_q.bitcnt == LAST_WORD_BIT)
                    begin
                        // Only one word per frame; later bits wait for chip select to rise.
                        r_d.state = ST_IDLE;
                        if (w[KIND_BIT])
                        begin
                            // Configuration write; bits 2:0 are dropped by field().
                            case (sel_code(w))
                                SEL_UPPER_SCAN: r_d.scan_en[CHAN_N-1:SEQ_W] = field(w);
                                SEL_LOWER_SCAN: r_d.scan_en[SEQ_W-1:0] = field(w);
                                SEL_SEQUENCE:
                                begin
                                    // The pattern follows in the next frame.
                                    r_d.seq_count = field(w);
                                    r_d.pat_armed = 1'b1;
                                end
                                default: r_d.state = ST_IDLE;
                            endcase
                            if (r_q.running)
                            begin
                                // The conversion in flight ends under the old scan setup.
                                r_d.running    = 1'b0;
                                r_d.data_valid = 1'b0;
                            end
                        end
                        else
                        begin
                            // Mode word waits for the next chip-select fall.
                            r_d.mode_pending = 1'b1;
                            r_d.mode_word    = w;
                        end
                    end
                end
                ST_PATTERN:
                begin
                    r_d.shift  = {{(WORD_W-NIB_W){1'b0}}, nib};
                    r_d.bitcnt = {2'h0, r_q.bitcnt[1:0] + 2'h1};
                    if (r_q.bitcnt[1:0] == LAST_NIB_BIT)
                    begin
                        r_d.bitcnt = '0;
                        if (in_len(r_q.nib_idx, r_q.seq_count))
                        begin
                            r_d.mem[r_q.nib_idx[SEQ_W-1:0]] = nib;
                            r_d.rcvd                         = r_q.nib_idx + 1'b1;
                            r_d.nib_idx                      = r_q.nib_idx + 1'b1;
                        end
                        // Surplus entries fall through here and are dropped.
                    end
                end
                ST_IDLE:
                begin
                    r_d.state = ST_IDLE;
                end
                default:
                begin
                    r_d.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            r_q         <= '0;
            r_q.cs_prev <= 1'b1;
            r_q.state   <= ST_IDLE;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign scan_enable    = r_q.scan_en;
    assign sequence_count = r_q.seq_count;
    assign conv_channel   = r_q.conv_chan;
    assign conv_start     = r_q.conv_start;
    assign seq_running    = r_q.running;
    assign data_valid     = r_q.data_valid;
    assign power_down     = r_q.power_down;

endmodule

// File: dv/ascfg_top_assertions.sv
// Concurrent checks on the scan and sequence configuration ports.
`timescale 1ns/1ps
module ascfg_checker (
    input wire logic                         sys_clk,
    input wire logic                         rst,
    input wire logic                         cs_n,
    input wire logic                         sclk,
    input wire logic                         din,
    input wire logic [ascfg_pkg::CHAN_N-1:0] scan_enable,
    input wire logic [ascfg_pkg::SEQ_W-1:0]  sequence_count,
    input wire logic [ascfg_pkg::NIB_W-1:0]  conv_channel,
    input wire logic                         conv_start,
    input wire logic                         seq_running,
    input wire logic                         data_valid,
    input wire logic                         power_down
);
    import ascfg_pkg::*;
    // Cycles since chip select went low; a start must follow a fall closely, not a long-held select.
    logic [3:0] cs_low_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst || cs_n)
            cs_low_q <= 4'h0;
        else if (cs_low_q != 4'hF)
            cs_low_q <= cs_low_q + 4'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_cs_release;
        ##[1:20] cs_n;
    endsequence
    property p_pulse; conv_start |=> !conv_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    property p_at_fall; conv_start |-> cs_low_q inside {[1:6]}; endproperty
    a_at_fall: assert property (p_at_fall) else $error("start not at select fall");
    property p_valid; conv_start |-> data_valid; endproperty
    a_valid: assert property (p_valid) else $error("start without valid");
    property p_run; seq_running |-> data_valid; endproperty
    a_run: assert property (p_run) else $error("running while invalid");
    property p_chan; $changed(conv_channel) |-> conv_start; endproperty
    a_chan: assert property (p_chan) else $error("channel moved without start");
    property p_scan; $changed(scan_enable) |-> !cs_n ##0 s_cs_release; endproperty
    a_scan: assert property (p_scan) else $error("scan enable changed outside a word");
    property p_seq; $changed(sequence_count) |-> !cs_n ##0 s_cs_release; endproperty
    a_seq: assert property (p_seq) else $error("count changed outside a word");
    property p_pd; $rose(power_down) |-> !seq_running; endproperty
    a_pd: assert property (p_pd) else $error("power down while running");
    property p_drop; $fell(data_valid) |-> !cs_n && !seq_running; endproperty
    a_drop: assert property (p_drop) else $error("valid dropped outside a config word");
    // A register write must trail a link clock rise by the synchroniser and edge-detect delay.
    property p_on_clk; ($changed(scan_enable) || $changed(sequence_count)) |-> sclk && $past(sclk, 3); endproperty
    a_on_clk: assert property (p_on_clk) else $error("register changed away from a link clock rise");
endmodule
bind ascfg_top ascfg_checker i_chk (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .scan_enable(scan_enable), .sequence_count(sequence_count), .conv_channel(conv_channel),
    .conv_start(conv_start), .seq_running(seq_running), .data_valid(data_valid), .power_down(power_down));

// File: dv/ascfg_host_model.sv
// Serial host that frames words and pattern nibbles onto the link pins.
`timescale 1ns/1ps
module ascfg_host_model (
    input  wire logic sys_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // The link clock only runs inside a frame; data flips after release so a stale bit never looks held.
    task automatic frame(input logic [31:0] bits, input int n);
        int i;
        tick(1);
        cs_n <= 1'b0;
        tick(8);
        for (i = n - 1; i >= 0; i--)
        begin
            din <= bits[i];
            tick(4);
            sclk <= 1'b1;
            tick(4);
            sclk <= 1'b0;
        end
        tick(8);
        cs_n <= 1'b1;
        din <= ~din;
        tick(16);
    endtask
    task automatic send_word(input logic [15:0] w);
        frame({16'h0000, w}, 16);
    endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the scan and sequence configuration decoder.
`timescale 1ns/1ps
module testbench;
    import ascfg_pkg::*;
    logic              sys_clk;
    logic              rst;
    logic              cs_n;
    logic              sclk;
    logic              din;
    logic [CHAN_N-1:0] scan_enable;
    logic [SEQ_W-1:0]  sequence_count;
    logic [NIB_W-1:0]  conv_channel;
    logic              conv_start;
    logic              seq_running;
    logic              data_valid;
    logic              power_down;
    int                num_errors;
    int                tests_run;
    logic [3:0]        chans[$];
    ascfg_host_model i_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din));
    ascfg_top i_dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
        .scan_enable(scan_enable), .sequence_count(sequence_count), .conv_channel(conv_channel),
        .conv_start(conv_start), .seq_running(seq_running), .data_valid(data_valid), .power_down(power_down));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
        if (conv_start === 1'b1)
            chans.push_back(conv_channel);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        #1;
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Loads a count and a pattern, starts with a mode word, then counts starts over empty frames.
    task automatic run_seq(input logic [7:0] cnt, input logic [31:0] pat, input int nb, input logic [15:0] mode,
                           input int falls, input logic [15:0] exp_ch, input int ne);
        int i;
        i_host.send_word({5'b10110, cnt, 3'b000});
        chk({8'h00, sequence_count}, {8'h00, cnt});
        i_host.frame(pat, nb);
        i_host.send_word(mode);
        chans.delete();
        repeat (falls) i_host.frame(32'h0, 0);
        chk(16'(chans.size()), 16'(ne));
        for (i = 0; i < ne && i < chans.size(); i++)
            chk({12'h000, chans[i]}, {12'h000, exp_ch[15-4*i -: 4]});
    endtask
    task automatic t_reset();
        chk(scan_enable, 16'h0000);
        chk({13'h0000, data_valid, seq_running, power_down}, 16'h0000);
        chk({8'h00, sequence_count}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_scan();
        i_host.send_word({5'b10100, 8'hA5, 3'b111});
        chk(scan_enable, 16'hA500);
        i_host.send_word({5'b10101, 8'h3C, 3'b010});
        chk(scan_enable, 16'hA53C);
        i_host.send_word({5'b10001, 8'hFF, 3'b000});
        chk(scan_enable, 16'hA53C);
        i_host.send_word({5'b10110, 8'hFF, 3'b000});
        chk({8'h00, sequence_count}, 16'h00FF);
        i_host.frame(32'h0, 0);
        $display("test scan done");
    endtask
    task automatic t_seq();
        run_seq(8'h02, 32'h00000059, 8, 16'h0008, 3, 16'h5900, 3);
        chk({14'h0000, power_down, seq_running}, 16'h0002);
        run_seq(8'h01, 32'h0000001E, 6, 16'h0000, 2, 16'h7000, 2);
        run_seq(8'h00, 32'h00000034, 8, 16'h0000, 2, 16'h3000, 1);
        $display("test sequence done");
    endtask
    task automatic t_mid();
        run_seq(8'h03, 32'h00001234, 16, 16'h0000, 1, 16'h1000, 1);
        chk({15'h0000, seq_running}, 16'h0001);
        i_host.send_word({5'b10100, 8'h0F, 3'b000});
        chk(scan_enable, 16'h0F3C);
        chk({14'h0000, seq_running, data_valid}, 16'h0000);
        chans.delete();
        i_host.frame(32'h0, 0);
        chk(16'(chans.size()), 16'h0000);
        i_host.send_word(16'h0000);
        i_host.frame(32'h0, 0);
        chk(16'(chans.size()), 16'h0001);
        chk({12'h000, conv_channel}, 16'h0001);
        chk({15'h0000, data_valid}, 16'h0001);
        $display("test mid sequence done");
    endtask
    // A mode word sent inside a running sequence lets the entry in flight convert, then restarts at entry 0.
    task automatic t_remode();
        chans.delete();
        i_host.send_word(16'h0000);
        i_host.frame(32'h0, 0);
        chk(16'(chans.size()), 16'h0002);
        chk({12'h000, chans[0]}, 16'h0002);
        chk({12'h000, chans[1]}, 16'h0001);
        chk({15'h0000, data_valid}, 16'h0001);
        $display("test mode restart done");
    endtask
    // A reset in mid-run must clear the scan, count and status outputs, and the link must work again after it.
    task automatic t_rst_mid();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        i_host.send_word({5'b10101, 8'h81, 3'b000});
        chk(scan_enable, 16'h0081);
        $display("test mid-run reset done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #1ms;
        num_errors++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        num_errors = 0;
        tests_run = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_scan();
        t_seq();
        t_mid();
        t_remode();
        t_rst_mid();
        complete_run();
    end
endmodule
